/* irq_pkg.sv */
// Package: constants, types and register map for the trap and wake-up interrupt block.
// Assumes an APB master on pclk and a core sequencer that reports instruction events.
`default_nettype none

package irq_pkg;

	localparam int WAKE_PINS = 8;
	localparam int ADDR_W = 12;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_WAKE_EDGE = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_WAKE_PEND = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_MASK_SRC = 12'h014;

	// Control register fields.
	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_GROUP_EN_BIT = 1;

	// Status register fields.
	localparam int ST_TRAP_BIT = 0;
	localparam int ST_WAKE_REQ_BIT = 1;
	localparam int ST_BOOT_BIT = 2;
	localparam int ST_IN_ISR_BIT = 3;
	localparam int ST_STATE_LSB = 4;

	// Number of maskable sources other than the wake-up port, ranked 3..14.
	localparam int NUM_MASKABLE = 12;

	// Vector low bytes.
	localparam logic [7:0] VEC_TRAP = 8'hFE;
	localparam logic [7:0] VEC_FIRST_MASKABLE = 8'hFA;
	localparam logic [7:0] VEC_WAKE = 8'hE2;
	localparam logic [7:0] VEC_DEFAULT = 8'hE0;
	localparam logic [7:0] VEC_STEP = 8'h02;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// Service state of the core, Gray coded along idle -> maskable -> trap.
	typedef enum logic [1:0] {
		SVC_IDLE = 2'b00,
		SVC_MASKABLE = 2'b01,
		SVC_TRAP = 2'b11
	} svc_state_t;

	// Instruction events reported by the core sequencer, one-cycle pulses.
	typedef struct packed {
		logic trap_fetch;
		logic clear_trap;
		logic vector_select;
		logic return_enable;
		logic low_power_wake;
	} core_evt_t;

	// Answer to the core after a vector select.
	typedef struct packed {
		logic valid;
		logic [7:0] pc_low;
	} vec_ans_t;

endpackage : irq_pkg

`default_nettype wire

/* wake_edge_cell.sv */
// Wake-up pin cell: edge detection, edge select and sticky pending latch.
// Assumes pin inputs are synchronous to pclk.
`default_nettype none

module wake_edge_cell
	import irq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic pin,
	input wire logic falling_sel,
	input wire logic clear,
	output logic pending
);

	logic prev_r;
	logic prev_nxt;
	logic pend_r;
	logic pend_nxt;
	logic hit;

	always_comb begin
		prev_nxt = pin;
		hit = falling_sel ? (prev_r & ~pin) : (~prev_r & pin);
		// A new edge wins over a clear in the same cycle.
		pend_nxt = hit | (pend_r & ~clear);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 1'b0;
			pend_r <= 1'b0;
		end else if (ce) begin
			prev_r <= prev_nxt;
			pend_r <= pend_nxt;
		end
	end

	assign pending = pend_r;

endmodule : wake_edge_cell

`default_nettype wire

/* vector_arbiter.sv */
// Priority arbiter: returns the vector low byte of the highest ranked active request.
// Purely combinational; the caller registers the answer.
`default_nettype none

module vector_arbiter
	import irq_pkg::*;
(
	input wire logic trap_req,
	input wire logic [NUM_MASKABLE-1:0] mask_req,
	input wire logic wake_req,
	output logic [7:0] vec
);

	always_comb begin
		vec = VEC_DEFAULT;
		if (wake_req) begin
			vec = VEC_WAKE;
		end
		// Index 0 is highest ranked, so scan from the lowest upward.
		for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
			if (mask_req[i]) begin
				vec = 8'(VEC_FIRST_MASKABLE - 8'(i * 2));
			end
		end
		if (trap_req) begin
			vec = VEC_TRAP;
		end
	end

endmodule : vector_arbiter

`default_nettype wire

/* trap_wake_irq.sv */
// Trap pending flag, wake-up port interrupts, nesting and boot ROM masking.
// Assumes an APB master on pclk and a core sequencer issuing one-cycle event pulses.
//
// Contract
// [RQ1] Trap pending blocks all maskable interrupts
// [RQ2] Clear-trap instruction clears flag, harmless if clear
// [RQ3] Trap pending is one bit, no nesting
// [RQ4] Eight edge wake inputs share one vector
// [RQ5] Per-pin wake enable gates each source
// [RQ6] Per-pin edge select picks rising or falling
// [RQ7] Per-pin pending latches edges until cleared
// [RQ8] Group enable allows or blocks wake interrupts
// [RQ9] Global enable gates every maskable request
// [RQ10] Wake with interrupt off resumes next instruction
// [RQ11] Wake with interrupt on runs service first
// [RQ12] Trap opcode raises top-priority trap immediately
// [RQ13] Trap routine accepts only another trap
// [RQ14] Maskable never preempts; trap preempts maskable
// [RQ15] Return instruction sets global enable again
// [RQ16] Boot ROM blocks interrupts, keeps global enable
// [RQ17] After boot ROM, held requests taken once
// [RQ18] Trap routine ends with two clears, restart
// [RQ19] Maskable routine ends with return or select; code ends it on return only
// [RQ20] Vector select gives E0..FE by rank
// [RQ21] Trap flag resets zero, sets on trap
// [RQ22] Wake request is pending and enable and group
//
// Our own choices: the APB slave port and the placing of the registers.
`default_nettype none

module trap_wake_irq
	import irq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [WAKE_PINS-1:0] wake_pins,
	input wire logic [NUM_MASKABLE-1:0] maskable_req,
	input wire core_evt_t core_evt,
	input wire logic in_boot_rom,
	output vec_ans_t vec_ans,
	output logic irq_to_core,
	output logic trap_pending_flag,
	output logic wake_resume_isr,
	output logic global_irq_enable
);

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	logic trap_r, trap_nxt;
	logic gie_r, gie_nxt;
	logic group_en_r, group_en_nxt;
	logic [WAKE_PINS-1:0] wake_en_r, wake_en_nxt;
	logic [WAKE_PINS-1:0] wake_edge_r, wake_edge_nxt;
	logic [NUM_MASKABLE-1:0] mask_en_r, mask_en_nxt;
	svc_state_t svc_r, svc_nxt;
	vec_ans_t vec_r, vec_nxt;
	logic irq_r, irq_nxt;
	logic resume_r, resume_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;

	logic [WAKE_PINS-1:0] wake_pend;
	logic [WAKE_PINS-1:0] wake_clr;
	logic wake_req;
	logic [NUM_MASKABLE-1:0] mask_act;
	logic maskable_any;
	logic maskable_ok;
	logic trap_set;
	logic [7:0] arb_vec;
	logic wr_acc;
	logic rd_acc;

	// -------------------------------------------------------------
	// Wake-up port cells
	// -------------------------------------------------------------
	// A write lands at the edge that completes the transfer, where pready is sampled high.
	assign wr_acc = psel & penable & pwrite & pready_r;
	assign rd_acc = psel & penable & ~pwrite & ~pready_r;

	// Writing ones to the pending register clears those bits.
	assign wake_clr = (wr_acc && paddr == OFS_WAKE_PEND) ? pwdata[WAKE_PINS-1:0] : '0;

	genvar g;
	generate
		for (g = 0; g < WAKE_PINS; g++) begin : g_wake // RQ4
			wake_edge_cell u_cell (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.pin(wake_pins[g]),
				.falling_sel(wake_edge_r[g]), // RQ6
				.clear(wake_clr[g]), // RQ7
				.pending(wake_pend[g])
			);
		end
	endgenerate

	// -------------------------------------------------------------
	// Arbitration
	// -------------------------------------------------------------
	assign wake_req = group_en_r & |(wake_pend & wake_en_r); // RQ22 RQ5 RQ8
	assign mask_act = maskable_req & mask_en_r;
	assign maskable_any = wake_req | (|mask_act);
	assign trap_set = core_evt.trap_fetch; // RQ12

	// Maskable sources need GLOBAL_IRQ_ENABLE, no trap, no routine in progress and no boot ROM.
	assign maskable_ok = gie_r & ~trap_r & (svc_r == SVC_IDLE) & ~in_boot_rom; // RQ1 RQ9 RQ14 RQ16

	vector_arbiter u_arb (
		.trap_req(trap_r | trap_set), // RQ12
		.mask_req(maskable_ok ? mask_act : '0),
		.wake_req(maskable_ok & wake_req),
		.vec(arb_vec)
	);

	// -------------------------------------------------------------
	// Configuration registers
	// -------------------------------------------------------------
	// Software-visible enables and edge selects. The return instruction may set
	// the global enable in the same cycle as a register write; the instruction wins,
	// so that a routine never ends with interrupts left off by a racing write.
	always_comb begin
		gie_nxt = gie_r;
		group_en_nxt = group_en_r;
		wake_en_nxt = wake_en_r;
		wake_edge_nxt = wake_edge_r;
		mask_en_nxt = mask_en_r;

		if (wr_acc) begin
			case (paddr)
				OFS_CTRL: begin
					gie_nxt = pwdata[CTRL_GIE_BIT];
					group_en_nxt = pwdata[CTRL_GROUP_EN_BIT];
				end
				OFS_WAKE_EN: wake_en_nxt = pwdata[WAKE_PINS-1:0];
				OFS_WAKE_EDGE: wake_edge_nxt = pwdata[WAKE_PINS-1:0];
				OFS_MASK_SRC: mask_en_nxt = pwdata[NUM_MASKABLE-1:0];
				default: begin
				end
			endcase
		end

		if (core_evt.return_enable) begin
			gie_nxt = 1'b1; // RQ15
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gie_r <= 1'b0;
			group_en_r <= 1'b0;
			wake_en_r <= RST_BYTE;
			wake_edge_r <= RST_BYTE;
			mask_en_r <= '0;
		end else if (ce) begin
			gie_r <= gie_nxt;
			group_en_r <= group_en_nxt;
			wake_en_r <= wake_en_nxt;
			wake_edge_r <= wake_edge_nxt;
			mask_en_r <= mask_en_nxt;
		end
	end

	// -------------------------------------------------------------
	// Interrupt control next state
	// -------------------------------------------------------------
	always_comb begin
		trap_nxt = trap_r;
		svc_nxt = svc_r;
		vec_nxt.valid = 1'b0;
		vec_nxt.pc_low = vec_r.pc_low;
		irq_nxt = 1'b0;
		// The wake decision holds until the next low-power exit replaces it.
		resume_nxt = resume_r;

		if (core_evt.clear_trap) begin
			trap_nxt = 1'b0; // RQ2 RQ3
		end

		if (core_evt.return_enable) begin
			svc_nxt = SVC_IDLE;
		end

		// Routine selection at the vector-select instruction.
		if (core_evt.vector_select) begin
			vec_nxt.valid = 1'b1;
			vec_nxt.pc_low = arb_vec; // RQ20
			if (trap_r) begin
				svc_nxt = SVC_TRAP; // RQ13
			end else if (arb_vec != VEC_DEFAULT) begin
				svc_nxt = SVC_MASKABLE;
			end
		end

		// Low-power wake: run the service only if the interrupt path is open.
		if (core_evt.low_power_wake) begin
			resume_nxt = maskable_ok & wake_req; // RQ10 RQ11
		end

		// Request to core: a trap unless in boot ROM, a maskable only when allowed.
		case (svc_r)
			SVC_IDLE: irq_nxt = trap_r | (maskable_ok & maskable_any); // RQ17
			SVC_MASKABLE: irq_nxt = trap_r; // RQ14
			SVC_TRAP: irq_nxt = trap_set; // RQ13
			default: irq_nxt = 1'b0;
		endcase

		// The set wins over a clear arriving in the same cycle.
		if (trap_set) begin
			trap_nxt = 1'b1; // RQ21 RQ12
			irq_nxt = 1'b1;
		end

		// Boot ROM code runs with every request held back, the trap included.
		// Flags and pending latches are kept, so the requests are taken on return.
		if (in_boot_rom) begin
			irq_nxt = 1'b0; // RQ16
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_r <= 1'b0; // RQ21
			svc_r <= SVC_IDLE;
			vec_r <= '0;
			irq_r <= 1'b0;
			resume_r <= 1'b0;
		end else if (ce) begin
			trap_r <= trap_nxt;
			svc_r <= svc_nxt;
			vec_r <= vec_nxt;
			irq_r <= irq_nxt;
			resume_r <= resume_nxt;
		end
	end

	// -------------------------------------------------------------
	// APB slave
	// -------------------------------------------------------------
	always_comb begin
		prdata_nxt = RD_ZERO;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		if (psel && penable && !pready_r) begin
			pready_nxt = 1'b1;
			case (paddr)
				OFS_CTRL: begin
					prdata_nxt[CTRL_GIE_BIT] = gie_r;
					prdata_nxt[CTRL_GROUP_EN_BIT] = group_en_r;
				end
				OFS_WAKE_EN: prdata_nxt[WAKE_PINS-1:0] = wake_en_r;
				OFS_WAKE_EDGE: prdata_nxt[WAKE_PINS-1:0] = wake_edge_r;
				OFS_WAKE_PEND: prdata_nxt[WAKE_PINS-1:0] = wake_pend;
				OFS_MASK_SRC: prdata_nxt[NUM_MASKABLE-1:0] = mask_en_r;
				OFS_STATUS: begin
					prdata_nxt[ST_TRAP_BIT] = trap_r;
					prdata_nxt[ST_WAKE_REQ_BIT] = wake_req;
					prdata_nxt[ST_BOOT_BIT] = in_boot_rom;
					prdata_nxt[ST_IN_ISR_BIT] = (svc_r != SVC_IDLE);
					prdata_nxt[ST_STATE_LSB +: 2] = svc_r;
				end
				default: pslverr_nxt = 1'b1;
			endcase
			if (!rd_acc) begin
				prdata_nxt = RD_ZERO;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= RD_ZERO;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign vec_ans = vec_r;
	assign irq_to_core = irq_r;
	assign trap_pending_flag = trap_r;
	assign wake_resume_isr = resume_r;
	assign global_irq_enable = gie_r;

endmodule : trap_wake_irq

`default_nettype wire

/* trap_wake_irq_props.sv */
// Checker for trap_wake_irq, bound to its top module.
// Assumes pclk alone and an active-low asynchronous presetn.
`default_nettype none
module trap_wake_irq_props
	import irq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire core_evt_t core_evt,
	input wire logic in_boot_rom,
	input wire vec_ans_t vec_ans,
	input wire logic irq_to_core,
	input wire logic trap_pending_flag,
	input wire logic global_irq_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_trap_set;
		ce && !in_boot_rom && core_evt.trap_fetch |=> trap_pending_flag && irq_to_core;
	endproperty
	a_trap_set: assert property (p_trap_set) else $error("trap not raised");
	property p_clear;
		ce && core_evt.clear_trap && !core_evt.trap_fetch |=> !trap_pending_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("trap not cleared");
	property p_fell;
		$fell(trap_pending_flag) |-> $past(core_evt.clear_trap);
	endproperty
	a_fell: assert property (p_fell) else $error("trap lost");
	property p_sel;
		ce && core_evt.vector_select |=> vec_ans.valid;
	endproperty
	a_sel: assert property (p_sel) else $error("no vector");
	property p_trap_vec;
		vec_ans.valid && $past(trap_pending_flag) |-> vec_ans.pc_low == VEC_TRAP;
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap outranked");
	property p_boot;
		in_boot_rom && $past(in_boot_rom) |-> !irq_to_core;
	endproperty
	a_boot: assert property (p_boot) else $error("boot not masked");
	property p_ret;
		ce && core_evt.return_enable |=> global_irq_enable;
	endproperty
	a_ret: assert property (p_ret) else $error("enable not set");
	property p_gate;
		$past(!global_irq_enable && !trap_pending_flag) && !global_irq_enable
			&& !trap_pending_flag |-> !irq_to_core;
	endproperty
	a_gate: assert property (p_gate) else $error("ungated request");
endmodule : trap_wake_irq_props
bind trap_wake_irq trap_wake_irq_props trap_wake_irq_props_i (.pclk(pclk), .presetn(presetn),
	.ce(ce), .core_evt(core_evt), .in_boot_rom(in_boot_rom), .vec_ans(vec_ans),
	.irq_to_core(irq_to_core), .trap_pending_flag(trap_pending_flag),
	.global_irq_enable(global_irq_enable));
`default_nettype wire

/* core_model.sv */
// Core sequencer and wake-up pin model for trap_wake_irq.
// Assumes its tasks are called just after a rising pclk edge.
`default_nettype none
module core_model
	import irq_pkg::*;
(
	input wire logic pclk,
	input wire vec_ans_t vec_ans,
	output var core_evt_t core_evt,
	output logic [WAKE_PINS-1:0] wake_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		core_evt = '0;
		wake_pins = '0;
	end
	task automatic pulse(input logic [4:0] ev);
		core_evt <= ev;
		@(posedge pclk);
		core_evt <= '0;
		@(posedge pclk);
	endtask : pulse
	task automatic pins(input logic [7:0] p);
		wake_pins <= p;
		repeat (2) @(posedge pclk);
	endtask : pins
	// Takes a vector; with fin set it also ends the routine in the way its kind needs.
	task automatic serve(output logic [7:0] vec, input logic fin);
		core_evt <= 5'h04;
		@(posedge pclk);
		core_evt <= '0;
		@(negedge pclk);
		vec = vec_ans.pc_low;
		@(posedge pclk);
		if (fin && vec === VEC_TRAP) begin
			pulse(5'h08);
			pulse(5'h08);
		end
		if (fin) begin
			pulse(5'h02);
		end
	endtask : serve
endmodule : core_model
`default_nettype wire

/* trap_wake_irq_tb_top.sv */
// Self-checking bench for trap_wake_irq with core_model on the core side.
// Assumes the checker file binds itself to the design.
`default_nettype none
module trap_wake_irq_tb_top
	import irq_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0;
	logic ce = 1'h1;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic in_boot_rom = 1'h0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [NUM_MASKABLE-1:0] maskable_req = '0;
	logic [31:0] prdata, r;
	logic pready, pslverr, irq_to_core, trap_pending_flag, wake_resume_isr, global_irq_enable, e;
	logic [WAKE_PINS-1:0] wake_pins;
	core_evt_t core_evt;
	vec_ans_t vec_ans;
	logic [7:0] v;
	int failures = 0;
	int n_checks = 0;
	always #5 pclk = ~pclk;
	trap_wake_irq trap_wake_irq_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wake_pins(wake_pins), .maskable_req(maskable_req),
		.core_evt(core_evt), .in_boot_rom(in_boot_rom), .vec_ans(vec_ans),
		.irq_to_core(irq_to_core), .trap_pending_flag(trap_pending_flag),
		.wake_resume_isr(wake_resume_isr), .global_irq_enable(global_irq_enable));
	core_model core_model_i (.pclk(pclk), .vec_ans(vec_ans), .core_evt(core_evt),
		.wake_pins(wake_pins));
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input string s, input logic [ADDR_W-1:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(s, x, r);
	endtask : rd
	// Compares irq, trap flag, resume-with-service and global enable under a mask.
	task automatic outs(input string s, input logic [3:0] x, input logic [3:0] m);
		@(negedge pclk);
		chk(s, {28'h0, x}, {28'h0, m & {irq_to_core, trap_pending_flag, wake_resume_isr,
			global_irq_enable}});
		@(posedge pclk);
	endtask : outs
	task automatic t_regs();
		rd("ctrl", OFS_CTRL, 32'h0);
		apb(1'h1, OFS_WAKE_EN, 32'h81);
		rd("wake_enable_reg", OFS_WAKE_EN, 32'h81);
		apb(1'h1, 12'h018, 32'hFF);
		chk("bad", 32'h1, {r[30:0], e});
	endtask : t_regs
	task automatic t_trap();
		core_model_i.pulse(5'h08);
		outs("clr", 4'h0, 4'hF);
		core_model_i.pulse(5'h10);
		outs("trap", 4'hC, 4'hF);
		rd("st", OFS_STATUS, 32'h1);
		core_model_i.serve(v, 1'h1);
		chk("tvec", 32'hFE, {24'h0, v});
		outs("done", 4'h1, 4'hF);
	endtask : t_trap
	task automatic t_wake();
		apb(1'h1, OFS_CTRL, 32'h3);
		apb(1'h1, OFS_WAKE_EDGE, 32'h80);
		core_model_i.pins(8'h82);
		rd("rise", OFS_WAKE_PEND, 32'h2);
		outs("off", 4'h1, 4'hF);
		core_model_i.pins(8'h03);
		rd("fall", OFS_WAKE_PEND, 32'h83);
		outs("req", 4'h9, 4'hF);
		apb(1'h1, OFS_CTRL, 32'h1);
		outs("grp", 4'h1, 4'hF);
		core_model_i.pulse(5'h01);
		outs("lp0", 4'h1, 4'hF);
		apb(1'h1, OFS_CTRL, 32'h3);
		core_model_i.pulse(5'h01);
		outs("lp1", 4'hB, 4'hF);
		core_model_i.serve(v, 1'h1);
		chk("wvec", 32'hE2, {24'h0, v});
		apb(1'h1, OFS_WAKE_PEND, 32'h83);
		rd("w1c", OFS_WAKE_PEND, 32'h0);
	endtask : t_wake
	task automatic t_nest();
		apb(1'h1, OFS_MASK_SRC, 32'h1);
		in_boot_rom <= 1'h1;
		maskable_req <= 12'h001;
		rd("boot", OFS_STATUS, 32'h4);
		outs("bmask", 4'h3, 4'hF);
		in_boot_rom <= 1'h0;
		rd("flash", OFS_STATUS, 32'h0);
		outs("held", 4'hB, 4'hF);
		core_model_i.serve(v, 1'h0);
		chk("evec", 32'hFA, {24'h0, v});
		rd("isr", OFS_STATUS, 32'h18);
		outs("nonest", 4'h0, 4'h8);
		core_model_i.pulse(5'h10);
		outs("pre", 4'hC, 4'hC);
		core_model_i.serve(v, 1'h1);
		chk("nvec", 32'hFE, {24'h0, v});
		outs("back", 4'hB, 4'hF);
		apb(1'h1, OFS_CTRL, 32'h2);
		outs("gie", 4'h2, 4'hF);
	endtask : t_nest
	// With the clock enable low a trap fetch must leave every flag untouched.
	task automatic t_hold();
		ce <= 1'h0;
		core_model_i.pulse(5'h10);
		outs("hold", 4'h2, 4'hF);
		ce <= 1'h1;
		@(posedge pclk);
	endtask : t_hold
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_trap();
		t_wake();
		t_nest();
		t_hold();
		test_done();
	end
	initial begin
		repeat (3000) @(posedge pclk);
		failures++;
		test_done();
	end
endmodule : trap_wake_irq_tb_top
`default_nettype wire
